// ==== pcicid_params.svh ====
// offsets, field positions, reset values and identity defaults for the config identity/command bank
`ifndef PCICID_PARAMS_SVH
`define PCICID_PARAMS_SVH
`define PCICID_OFS_MAKER       6'h00
`define PCICID_OFS_PART        6'h02
`define PCICID_OFS_CMD         6'h04
`define PCICID_MAKER_ID_DFLT   16'h1a2b
`define PCICID_PART_ID_DFLT    16'h3c4d
`define PCICID_CMD_RESET       16'h0000
`define PCICID_CMD_WR_MASK     16'h0167
`define PCICID_BIT_IO          0
`define PCICID_BIT_MEM         1
`define PCICID_BIT_MASTER      2
`define PCICID_BIT_SNOOP       5
`define PCICID_BIT_PARITY      6
`define PCICID_BIT_SYSERR      8
`define PCICID_NUM_FUNC        2
`endif

// ==== pcicid_pkg.sv ====
// types shared by the config identity/command bank
package pcicid_pkg;
  typedef struct packed {
    logic       io_space_enable;
    logic       mem_space_enable;
    logic       bus_master_enable;
    logic       palette_snoop_enable;
    logic       parity_response_enable;
    logic       syserr_drive_enable;
  } pcicid_cmd_s;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       func;
    logic [5:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } pcicid_cfg_req_s;
endpackage

// ==== pcicid_bank.sv ====
// identity words shared by both functions and per-function command registers of the config header
`timescale 1ns/1ns
`default_nettype none
`include "pcicid_params.svh"
module pcicid_bank #(
  parameter logic [15:0] MAKER_ID = `PCICID_MAKER_ID_DFLT, // arbitrary value
  parameter logic [15:0] PART_ID  = `PCICID_PART_ID_DFLT   // arbitrary value
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     arst_n_in,
  input  wire pcicid_pkg::pcicid_cfg_req_s cfg_req_in,
  output logic [31:0]                   cfg_rdata_out,
  output logic                          cfg_ack_out,
  input  wire logic                     addr_parity_err_in,
  input  wire logic                     data_parity_err_in,
  output pcicid_pkg::pcicid_cmd_s       func0_cmd_out,
  output pcicid_pkg::pcicid_cmd_s       func1_cmd_out,
  output logic                          syserr_assert_out,
  output logic                          perr_assert_out
);
  localparam logic [15:0] CMD_RST  = `PCICID_CMD_RESET;
  localparam logic [15:0] CMD_MASK = `PCICID_CMD_WR_MASK;

  // function 0 writable command bits
  logic        io0_q;
  logic        io0_d;
  logic        mem0_q;
  logic        mem0_d;
  logic        mst0_q;
  logic        mst0_d;
  logic        snp0_q;
  logic        snp0_d;
  logic        par0_q;
  logic        par0_d;
  logic        ser0_q;
  logic        ser0_d;

  // function 1 keeps its own copy; no bit is shared between the functions
  logic        io1_q;
  logic        io1_d;
  logic        mem1_q;
  logic        mem1_d;
  logic        mst1_q;
  logic        mst1_d;
  logic        snp1_q;
  logic        snp1_d;
  logic        par1_q;
  logic        par1_d;
  logic        ser1_q;
  logic        ser1_d;

  // request decode
  logic        wr_cmd0;
  logic        wr_cmd1;
  logic        lane0;
  logic        lane1;
  logic        rd_req;
  logic        w_io;
  logic        w_mem;
  logic        w_mst;
  logic        w_snp;
  logic        w_par;
  logic        w_ser;

  // read-back words and the registered answer
  logic [15:0] cmd0_view;
  logic [15:0] cmd1_view;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ack_q;
  logic        ack_d;

  // combined error enables and the registered error strobes
  logic        any_syserr_en;
  logic        any_parity_en;
  logic        syserr_q;
  logic        syserr_d;
  logic        perr_q;
  logic        perr_d;

  // true when the request writes the command word of function fn
  function automatic logic cmd_write_hit(
    input pcicid_pkg::pcicid_cfg_req_s r,
    input logic                        fn
  );
    logic hit;
    hit = 1'b0;
    if (r.valid) begin
      if (r.write) begin
        if (r.offset == `PCICID_OFS_CMD) begin
          if (r.func == fn) begin
            hit = 1'b1;
          end
        end
      end
    end
    return hit;
  endfunction

  // a write touches a bit only when the byte lane holding it is enabled
  function automatic logic next_bit(
    input logic cur,
    input logic hit,
    input logic lane,
    input logic wbit
  );
    logic nxt;
    nxt = cur;
    if (hit && lane) begin
      nxt = wbit;
    end
    return nxt;
  endfunction

  // read-back word; bits outside the writable set stay tied low
  function automatic logic [15:0] cmd_view(
    input logic io,
    input logic mem,
    input logic mst,
    input logic snp,
    input logic par,
    input logic ser
  );
    logic [15:0] v;
    v = CMD_RST;
    v[`PCICID_BIT_IO]     = io;
    v[`PCICID_BIT_MEM]    = mem;
    v[`PCICID_BIT_MASTER] = mst;
    v[`PCICID_BIT_SNOOP]  = snp;
    v[`PCICID_BIT_PARITY] = par;
    v[`PCICID_BIT_SYSERR] = ser;
    return v & CMD_MASK;
  endfunction

  // decoded enables handed to the rest of the function
  function automatic pcicid_pkg::pcicid_cmd_s unpack_cmd(
    input logic [15:0] c
  );
    pcicid_pkg::pcicid_cmd_s s;
    s.io_space_enable        = c[`PCICID_BIT_IO];
    s.mem_space_enable       = c[`PCICID_BIT_MEM];
    s.bus_master_enable      = c[`PCICID_BIT_MASTER];
    s.palette_snoop_enable   = c[`PCICID_BIT_SNOOP];
    s.parity_response_enable = c[`PCICID_BIT_PARITY];
    s.syserr_drive_enable    = c[`PCICID_BIT_SYSERR];
    return s;
  endfunction

  // write strobes, one per function
  always_comb begin
    wr_cmd0 = cmd_write_hit(cfg_req_in, 1'b0);
    wr_cmd1 = cmd_write_hit(cfg_req_in, 1'b1);
  end

  // read strobe; writes never load read data
  always_comb begin
    rd_req = cfg_req_in.valid & ~cfg_req_in.write;
  end

  // byte lanes: lane 0 holds bits 7:0, lane 1 bits 15:8
  always_comb begin
    lane0 = cfg_req_in.byte_en[0];
    lane1 = cfg_req_in.byte_en[1];
  end

  // write data bits, same for both functions
  always_comb begin
    w_io  = cfg_req_in.wdata[`PCICID_BIT_IO];
    w_mem = cfg_req_in.wdata[`PCICID_BIT_MEM];
    w_mst = cfg_req_in.wdata[`PCICID_BIT_MASTER];
    w_snp = cfg_req_in.wdata[`PCICID_BIT_SNOOP];
    w_par = cfg_req_in.wdata[`PCICID_BIT_PARITY];
    w_ser = cfg_req_in.wdata[`PCICID_BIT_SYSERR];
  end

  // next command bits of function 0
  always_comb begin
    io0_d  = next_bit(io0_q, wr_cmd0, lane0, w_io);
    mem0_d = next_bit(mem0_q, wr_cmd0, lane0, w_mem);
    mst0_d = next_bit(mst0_q, wr_cmd0, lane0, w_mst);
    snp0_d = next_bit(snp0_q, wr_cmd0, lane0, w_snp);
    par0_d = next_bit(par0_q, wr_cmd0, lane0, w_par);
    ser0_d = next_bit(ser0_q, wr_cmd0, lane1, w_ser);
  end

  // next command bits of function 1
  always_comb begin
    io1_d  = next_bit(io1_q, wr_cmd1, lane0, w_io);
    mem1_d = next_bit(mem1_q, wr_cmd1, lane0, w_mem);
    mst1_d = next_bit(mst1_q, wr_cmd1, lane0, w_mst);
    snp1_d = next_bit(snp1_q, wr_cmd1, lane0, w_snp);
    par1_d = next_bit(par1_q, wr_cmd1, lane0, w_par);
    ser1_d = next_bit(ser1_q, wr_cmd1, lane1, w_ser);
  end

  // read-back words of both functions
  assign cmd0_view = cmd_view(io0_q, mem0_q, mst0_q, snp0_q, par0_q, ser0_q);
  assign cmd1_view = cmd_view(io1_q, mem1_q, mst1_q, snp1_q, par1_q, ser1_q);

  // every request is answered one cycle later
  always_comb begin
    ack_d = cfg_req_in.valid;
  end

  // read answer; unmapped offsets and writes return zero
  // the part identifier is the upper half of the dword at offset 0
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_req) begin
      unique case (cfg_req_in.offset)
        `PCICID_OFS_MAKER: begin
          rdata_d = {PART_ID, MAKER_ID};
        end
        `PCICID_OFS_CMD: begin
          if (cfg_req_in.func) begin
            rdata_d = {16'h0000, cmd1_view};
          end else begin
            rdata_d = {16'h0000, cmd0_view};
          end
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // both functions feed one error path, so their enables are ORed
  // each function still reads back only its own stored bits
  assign any_syserr_en = ser0_q | ser1_q;
  assign any_parity_en = par0_q | par1_q;

  // address parity errors need both enables
  always_comb begin
    syserr_d = 1'b0;
    if (addr_parity_err_in && any_syserr_en && any_parity_en) begin
      syserr_d = 1'b1;
    end
  end

  // data parity errors need only the response enable
  always_comb begin
    perr_d = 1'b0;
    if (data_parity_err_in && any_parity_en) begin
      perr_d = 1'b1;
    end
  end

  // function 0 command register; hardwired bits have no flop at all
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io0_q  <= CMD_RST[`PCICID_BIT_IO];
      mem0_q <= CMD_RST[`PCICID_BIT_MEM];
      mst0_q <= CMD_RST[`PCICID_BIT_MASTER];
      snp0_q <= CMD_RST[`PCICID_BIT_SNOOP];
      par0_q <= CMD_RST[`PCICID_BIT_PARITY];
      ser0_q <= CMD_RST[`PCICID_BIT_SYSERR];
    end else begin
      io0_q  <= io0_d;
      mem0_q <= mem0_d;
      mst0_q <= mst0_d;
      snp0_q <= snp0_d;
      par0_q <= par0_d;
      ser0_q <= ser0_d;
    end
  end

  // function 1 command register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io1_q  <= CMD_RST[`PCICID_BIT_IO];
      mem1_q <= CMD_RST[`PCICID_BIT_MEM];
      mst1_q <= CMD_RST[`PCICID_BIT_MASTER];
      snp1_q <= CMD_RST[`PCICID_BIT_SNOOP];
      par1_q <= CMD_RST[`PCICID_BIT_PARITY];
      ser1_q <= CMD_RST[`PCICID_BIT_SYSERR];
    end else begin
      io1_q  <= io1_d;
      mem1_q <= mem1_d;
      mst1_q <= mst1_d;
      snp1_q <= snp1_d;
      par1_q <= par1_d;
      ser1_q <= ser1_d;
    end
  end

  // answer strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // read data
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // system error strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      syserr_q <= 1'b0;
    end else begin
      syserr_q <= syserr_d;
    end
  end

  // data parity strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      perr_q <= 1'b0;
    end else begin
      perr_q <= perr_d;
    end
  end

  // outputs straight from flops
  assign cfg_rdata_out     = rdata_q;
  assign cfg_ack_out       = ack_q;
  assign func0_cmd_out     = unpack_cmd(cmd0_view);
  assign func1_cmd_out     = unpack_cmd(cmd1_view);
  assign syserr_assert_out = syserr_q;
  assign perr_assert_out   = perr_q;
endmodule
`default_nettype wire

// ==== pcicid_bank_properties.sv ====
// port assertions for the config identity/command bank
`timescale 1ns/1ns
`default_nettype none
module pcicid_bank_properties (
  input wire logic                        core_clk_in,
  input wire logic                        arst_n_in,
  input wire pcicid_pkg::pcicid_cfg_req_s cfg_req_in,
  input wire logic                        addr_parity_err_in,
  input wire logic                        data_parity_err_in,
  input wire pcicid_pkg::pcicid_cmd_s     func0_cmd_out,
  input wire pcicid_pkg::pcicid_cmd_s     func1_cmd_out,
  input wire logic                        syserr_assert_out,
  input wire logic                        perr_assert_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire ser = func0_cmd_out.syserr_drive_enable | func1_cmd_out.syserr_drive_enable;
  wire par = func0_cmd_out.parity_response_enable | func1_cmd_out.parity_response_enable;
  sequence s_cause; addr_parity_err_in && ser && par; endsequence
  property p_serr_on; s_cause |=> syserr_assert_out; endproperty
  a_serr_on: assert property (p_serr_on) else $error("syserr missing");
  property p_serr_off; !addr_parity_err_in |=> !syserr_assert_out; endproperty
  a_serr_off: assert property (p_serr_off) else $error("syserr stray");
  property p_syserr_drive_enable; !(ser && par) |=> !syserr_assert_out; endproperty
  a_syserr_drive_enable: assert property (p_syserr_drive_enable) else $error("syserr ungated");
  property p_perr; 1 |=> perr_assert_out == $past(data_parity_err_in && par); endproperty
  a_perr: assert property (p_perr) else $error("perr wrong");
  property p_idle; !cfg_req_in.valid |=> $stable(func0_cmd_out) && $stable(func1_cmd_out); endproperty
  a_idle: assert property (p_idle) else $error("cmd moved idle");
  property p_f0; cfg_req_in.func |=> $stable(func0_cmd_out); endproperty
  a_f0: assert property (p_f0) else $error("func0 disturbed");
  property p_f1; !cfg_req_in.func |=> $stable(func1_cmd_out); endproperty
  a_f1: assert property (p_f1) else $error("func1 disturbed");
  property p_ro; !cfg_req_in.write || cfg_req_in.offset != 6'h04 |=> $stable({func0_cmd_out, func1_cmd_out});
  endproperty
  a_ro: assert property (p_ro) else $error("cmd moved by read");
endmodule
bind pcicid_bank pcicid_bank_properties u_props (.core_clk_in, .arst_n_in, .cfg_req_in, .addr_parity_err_in,
  .data_parity_err_in, .func0_cmd_out, .func1_cmd_out, .syserr_assert_out, .perr_assert_out);
`default_nettype wire

// ==== pcicid_host.sv ====
// host config master model
`timescale 1ns/1ns
`default_nettype none
module pcicid_host (
  input  wire logic                   core_clk_in,
  input  wire logic                   ack_in,
  input  wire logic [31:0]            rdata_in,
  output var pcicid_pkg::pcicid_cfg_req_s req_out
);
  initial req_out = '0;
  task automatic cfg(input logic w, f, input logic [5:0] o, input logic [3:0] b, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk_in);
    req_out <= '{1'b1, w, f, o, b, d};
    @(posedge core_clk_in);
    req_out <= {1'b0, ~req_out[43:0]}; // released fields toggle, so stale values never look valid
    #1 r = ack_in ? rdata_in : ~rdata_in;
  endtask
endmodule
`default_nettype wire

// ==== pcicid_bank_bench.sv ====
// self-checking bench for the config identity/command bank
`timescale 1ns/1ns
`default_nettype none
module pcicid_bank_bench;
  typedef struct packed {logic w; logic f; logic [5:0] o; logic [3:0] b; logic [31:0] x;} pcicid_row_s;
  logic                        core_clk_in = 1'b0;
  logic                        arst_n_in = 1'b0;
  logic                        ape = 1'b0;
  logic                        dpe = 1'b0;
  logic                        ack, serr, perr;
  logic [31:0]                 rdata, got;
  pcicid_pkg::pcicid_cfg_req_s req;
  pcicid_pkg::pcicid_cmd_s     f0, f1;
  int                          fail_count = 0;
  int                          check_count = 0;
  int                          cyc = 0;
  // x is write data for writes and expected read data for reads
  pcicid_row_s rows [9] = '{'{1'h0, 1'h0, 6'h00, 4'h0, 32'h3c4d1a2b}, '{1'h1, 1'h1, 6'h04, 4'h3, 32'h0000ffff},
    '{1'h0, 1'h1, 6'h04, 4'h0, 32'h00000167}, '{1'h0, 1'h0, 6'h04, 4'h0, 32'h00000000},
    '{1'h1, 1'h0, 6'h00, 4'hf, 32'hffffffff}, '{1'h0, 1'h0, 6'h00, 4'h0, 32'h3c4d1a2b},
    '{1'h1, 1'h0, 6'h04, 4'h1, 32'h0000ff66}, '{1'h0, 1'h0, 6'h04, 4'h0, 32'h00000066},
    '{1'h0, 1'h1, 6'h08, 4'h0, 32'h00000000}};
  pcicid_host u_host (.core_clk_in, .ack_in(ack), .rdata_in(rdata), .req_out(req));
  pcicid_bank u_dut (.core_clk_in, .arst_n_in, .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_ack_out(ack),
    .addr_parity_err_in(ape), .data_parity_err_in(dpe), .func0_cmd_out(f0), .func1_cmd_out(f1),
    .syserr_assert_out(serr), .perr_assert_out(perr));
  always #4 core_clk_in = ~core_clk_in;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rst();
    @(posedge core_clk_in);
    arst_n_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
  endtask
  task automatic pulse(input logic [31:0] es, input logic [31:0] ep);
    @(posedge core_clk_in);
    ape <= 1'b1;
    dpe <= 1'b1;
    @(posedge core_clk_in);
    ape <= 1'b0;
    dpe <= 1'b0;
    #1 chk("syserr", es, {31'h0, serr});
    chk("perr", ep, {31'h0, perr});
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      u_host.cfg(rows[i].w, rows[i].f, rows[i].o, rows[i].b, rows[i].x, got);
      chk("rdata", rows[i].w ? 32'h0 : rows[i].x, got);
    end
    chk("cmd", 32'h000007bf, {20'h0, f0, f1});
    pulse(32'h1, 32'h1);
    rst();
    chk("ack", 32'h0, {31'h0, ack});
    pulse(32'h0, 32'h0);
    u_host.cfg(1'b1, 1'b0, 6'h04, 4'h3, 32'h00000100, got);
    pulse(32'h0, 32'h0);
    u_host.cfg(1'b1, 1'b1, 6'h04, 4'h3, 32'h00000040, got);
    pulse(32'h1, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
